// >>> logic/spi_slave_byte_port.sv
// Byte-wide SPI slave port: serial framing on the SPI clock, one-byte
// transmit and receive slots handed to system logic on ref_clk_i.
// Assumes the master keeps to the framing; SCLK may stop between frames.
`timescale 1ns/1ps
module spi_slave_byte_port (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       spi_sclk_i,
    input  wire logic       spi_cs_i,
    input  wire logic       spi_sdi_i,
    output logic            spi_sdo_o,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_valid_i,
    output logic            tx_ready_o,
    output logic [7:0]      rx_data_o,
    output logic            rx_valid_o,
    input  wire logic       rx_ready_i,
    input  wire logic       rx_full_irq_enable_i,
    input  wire logic       tx_empty_irq_enable_i
);

    // --------------------------------------------------------------
    // Declarations
    // --------------------------------------------------------------
    spi_byte_port_pkg::link_state_t state_q, state_d;
    spi_byte_port_pkg::op_t         op_q, op_d;
    logic [2:0] cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d;
    logic       sdo_q, sdo_d;
    logic       rd_ok_q, rd_ok_d;
    logic       tx_taken_q, tx_taken_d;
    logic       rx_put_q, rx_put_d;
    logic [7:0] rx_word_q, rx_word_d;
    logic       tx_put_meta_q, tx_put_sync_q;
    logic       rx_got_meta_q, rx_got_sync_q;
    logic [1:0] irq_en_meta_q, irq_en_sync_q;
    logic       tx_avail;
    logic       rx_free;
    logic [7:0] status_byte;

    logic       tx_put_q, tx_put_d;
    logic [7:0] tx_hold_q, tx_hold_d;
    logic       tx_ready_q, tx_ready_d;
    logic       rx_got_q, rx_got_d;
    logic [7:0] rx_out_q, rx_out_d;
    logic       rx_valid_q, rx_valid_d;
    logic       tx_taken_meta_q, tx_taken_sync_q;
    logic       rx_put_meta_q, rx_put_sync_q;
    logic       tx_load;

    // --------------------------------------------------------------
    // SPI domain synchronisers
    // --------------------------------------------------------------
    // Only the toggles and enable levels cross; the byte registers stay
    // still while their toggle says they are owned by the reader.
    always_ff @(posedge spi_sclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_put_meta_q <= 1'b0;
            tx_put_sync_q <= 1'b0;
            rx_got_meta_q <= 1'b0;
            rx_got_sync_q <= 1'b0;
            irq_en_meta_q <= 2'h0;
            irq_en_sync_q <= 2'h0;
        end else begin
            tx_put_meta_q <= tx_put_q;
            tx_put_sync_q <= tx_put_meta_q;
            rx_got_meta_q <= rx_got_q;
            rx_got_sync_q <= rx_got_meta_q;
            irq_en_meta_q <= {tx_empty_irq_enable_i, rx_full_irq_enable_i};
            irq_en_sync_q <= irq_en_meta_q;
        end
    end

    assign tx_avail = (tx_put_sync_q != tx_taken_q);
    assign rx_free  = (rx_got_sync_q == rx_put_q);

    always_comb begin
        status_byte = spi_byte_port_pkg::BYTE_RESET;
        status_byte[spi_byte_port_pkg::RX_FULL_BIT]   = !rx_free;
        status_byte[spi_byte_port_pkg::TX_EMPTY_BIT]  = !tx_avail;
        status_byte[spi_byte_port_pkg::RX_IRQ_EN_BIT] = irq_en_sync_q[0];
        status_byte[spi_byte_port_pkg::TX_IRQ_EN_BIT] = irq_en_sync_q[1];
    end

    // --------------------------------------------------------------
    // SPI framing
    // --------------------------------------------------------------
    // Runs on the master's rising SCLK itself
    always_comb begin
        state_d    = state_q;
        op_d       = op_q;
        cnt_d      = cnt_q;
        shift_d    = shift_q;
        sdo_d      = 1'b0;
        rd_ok_d    = rd_ok_q;
        tx_taken_d = tx_taken_q;
        rx_put_d   = rx_put_q;
        rx_word_d  = rx_word_q;
        // Select lost mid-frame drops the partial byte
        if (state_q != spi_byte_port_pkg::ST_IDLE && !spi_cs_i) begin
            state_d = spi_byte_port_pkg::ST_IDLE;
        end else begin
            case (state_q)
                // Start on data and select high
                spi_byte_port_pkg::ST_IDLE: begin
                    if (spi_cs_i && spi_sdi_i) begin
                        state_d = spi_byte_port_pkg::ST_DIR;
                    end
                end
                spi_byte_port_pkg::ST_DIR: begin
                    op_d    = spi_byte_port_pkg::op_t'({spi_sdi_i, 1'b0});
                    state_d = spi_byte_port_pkg::ST_TGT;
                end
                // Operation decode from both setup bits
                spi_byte_port_pkg::ST_TGT: begin
                    op_d    = spi_byte_port_pkg::op_t'({op_q[1], spi_sdi_i});
                    cnt_d   = spi_byte_port_pkg::CNT_RESET;
                    state_d = spi_byte_port_pkg::ST_DATA;
                    rd_ok_d = 1'b0;
                    shift_d = spi_byte_port_pkg::BYTE_RESET;
                    if (op_q[1] && !spi_sdi_i) begin
                        // Head byte, stale copy when empty
                        shift_d = tx_hold_q;
                        rd_ok_d = tx_avail;
                        sdo_d   = tx_hold_q[7];
                    end else if (op_q[1] && spi_sdi_i) begin
                        shift_d = status_byte;
                        sdo_d   = status_byte[7];
                    end
                end
                spi_byte_port_pkg::ST_DATA: begin
                    cnt_d = cnt_q + 3'h1;
                    if (op_q == spi_byte_port_pkg::OP_WRITE) begin
                        shift_d = {shift_q[6:0], spi_sdi_i};
                    end else if (cnt_q != spi_byte_port_pkg::LAST_DATA_CNT)
                    begin
                        sdo_d   = shift_q[6];
                        shift_d = {shift_q[6:0], 1'b0};
                    end else if (op_q == spi_byte_port_pkg::OP_READ) begin
                        // Valid byte leaves the slot here
                        sdo_d = rd_ok_q ? spi_byte_port_pkg::STAT_OK
                                        : spi_byte_port_pkg::STAT_BAD;
                        if (rd_ok_q) begin
                            tx_taken_d = !tx_taken_q;
                        end
                    end else if (op_q == spi_byte_port_pkg::OP_NONE) begin
                        sdo_d = spi_byte_port_pkg::STAT_BAD;
                    end else begin
                        sdo_d = spi_byte_port_pkg::STAT_OK;
                    end
                    if (cnt_q == spi_byte_port_pkg::LAST_DATA_CNT) begin
                        state_d = spi_byte_port_pkg::ST_STAT;
                    end
                end
                spi_byte_port_pkg::ST_STAT: begin
                    state_d = spi_byte_port_pkg::ST_FINAL;
                    if (op_q == spi_byte_port_pkg::OP_WRITE) begin
                        sdo_d = rx_free ? spi_byte_port_pkg::STAT_OK
                                        : spi_byte_port_pkg::STAT_BAD;
                        if (rx_free) begin
                            rx_word_d = shift_q;
                            rx_put_d  = !rx_put_q;
                        end
                    end
                end
                spi_byte_port_pkg::ST_FINAL: begin
                    state_d = spi_byte_port_pkg::ST_IDLE;
                end
                default: begin
                    state_d = spi_byte_port_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge spi_sclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q    <= spi_byte_port_pkg::ST_IDLE;
            op_q       <= spi_byte_port_pkg::OP_WRITE;
            cnt_q      <= spi_byte_port_pkg::CNT_RESET;
            shift_q    <= spi_byte_port_pkg::BYTE_RESET;
            sdo_q      <= 1'b0;
            rd_ok_q    <= 1'b0;
            tx_taken_q <= 1'b0;
            rx_put_q   <= 1'b0;
            rx_word_q  <= spi_byte_port_pkg::BYTE_RESET;
        end else begin
            state_q    <= state_d;
            op_q       <= op_d;
            cnt_q      <= cnt_d;
            shift_q    <= shift_d;
            sdo_q      <= sdo_d;
            rd_ok_q    <= rd_ok_d;
            tx_taken_q <= tx_taken_d;
            rx_put_q   <= rx_put_d;
            rx_word_q  <= rx_word_d;
        end
    end

    assign spi_sdo_o = sdo_q;

    // --------------------------------------------------------------
    // System domain slots
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_taken_meta_q <= 1'b0;
            tx_taken_sync_q <= 1'b0;
            rx_put_meta_q   <= 1'b0;
            rx_put_sync_q   <= 1'b0;
        end else begin
            tx_taken_meta_q <= tx_taken_q;
            tx_taken_sync_q <= tx_taken_meta_q;
            rx_put_meta_q   <= rx_put_q;
            rx_put_sync_q   <= rx_put_meta_q;
        end
    end

    assign tx_load = tx_valid_i && tx_ready_q;

    // Slot loads and unloads run on the system clock
    always_comb begin
        tx_put_d   = tx_load ? !tx_put_q : tx_put_q;
        tx_hold_d  = tx_load ? tx_data_i : tx_hold_q;
        tx_ready_d = (tx_put_d == tx_taken_sync_q);
        rx_got_d   = rx_got_q;
        rx_out_d   = rx_out_q;
        rx_valid_d = rx_valid_q;
        if (rx_valid_q && rx_ready_i) begin
            rx_valid_d = 1'b0;
            rx_got_d   = !rx_got_q;
        end else if (!rx_valid_q && (rx_put_sync_q != rx_got_q)) begin
            rx_out_d   = rx_word_q;
            rx_valid_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_put_q   <= 1'b0;
            tx_hold_q  <= spi_byte_port_pkg::BYTE_RESET;
            tx_ready_q <= 1'b0;
            rx_got_q   <= 1'b0;
            rx_out_q   <= spi_byte_port_pkg::BYTE_RESET;
            rx_valid_q <= 1'b0;
        end else begin
            tx_put_q   <= tx_put_d;
            tx_hold_q  <= tx_hold_d;
            tx_ready_q <= tx_ready_d;
            rx_got_q   <= rx_got_d;
            rx_out_q   <= rx_out_d;
            rx_valid_q <= rx_valid_d;
        end
    end

    assign tx_ready_o = tx_ready_q;
    assign rx_data_o  = rx_out_q;
    assign rx_valid_o = rx_valid_q;

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    a_start_detect: assert property (
        @(posedge spi_sclk_i) disable iff (!rst_n_i)
        state_q == spi_byte_port_pkg::ST_IDLE && spi_cs_i && spi_sdi_i
        |=> state_q == spi_byte_port_pkg::ST_DIR)
        else $error("start not taken");

    a_frame_length: assert property (
        @(posedge spi_sclk_i) disable iff (!rst_n_i)
        state_q == spi_byte_port_pkg::ST_DIR && spi_cs_i
        ##1 spi_cs_i[*8] ##1 spi_cs_i[*2]
        |=> state_q == spi_byte_port_pkg::ST_FINAL)
        else $error("frame length wrong");

    a_frame_end: assert property (
        @(posedge spi_sclk_i) disable iff (!rst_n_i)
        state_q == spi_byte_port_pkg::ST_FINAL
        |=> state_q == spi_byte_port_pkg::ST_IDLE)
        else $error("frame did not end");

    a_cs_abort: assert property (
        @(posedge spi_sclk_i) disable iff (!rst_n_i)
        state_q != spi_byte_port_pkg::ST_IDLE && !spi_cs_i
        |=> state_q == spi_byte_port_pkg::ST_IDLE && !sdo_q
            && $stable(rx_put_q) && $stable(tx_taken_q))
        else $error("abort not clean");

    a_read_msb: assert property (
        @(posedge spi_sclk_i) disable iff (!rst_n_i)
        state_q == spi_byte_port_pkg::ST_TGT && spi_cs_i && op_q[1]
        && !spi_sdi_i && tx_avail
        |=> sdo_q == tx_hold_q[7] ##1 sdo_q == $past(shift_q[6]))
        else $error("read byte order wrong");

    a_read_status: assert property (
        @(posedge spi_sclk_i) disable iff (!rst_n_i)
        state_q == spi_byte_port_pkg::ST_DATA && spi_cs_i
        && op_q == spi_byte_port_pkg::OP_READ
        && cnt_q == spi_byte_port_pkg::LAST_DATA_CNT
        |=> sdo_q == !$past(rd_ok_q) && tx_taken_q != $past(tx_taken_q)
            == $past(rd_ok_q))
        else $error("read status wrong");

    a_write_status: assert property (
        @(posedge spi_sclk_i) disable iff (!rst_n_i)
        state_q == spi_byte_port_pkg::ST_STAT && spi_cs_i
        && op_q == spi_byte_port_pkg::OP_WRITE
        |=> sdo_q == !$past(rx_free)
            && (rx_put_q != $past(rx_put_q)) == $past(rx_free)
            && (!$past(rx_free) || rx_word_q == $past(shift_q)))
        else $error("write status wrong");

    a_stat_zero: assert property (
        @(posedge spi_sclk_i) disable iff (!rst_n_i)
        state_q == spi_byte_port_pkg::ST_DATA && spi_cs_i
        && op_q == spi_byte_port_pkg::OP_STATUS
        && cnt_q == spi_byte_port_pkg::LAST_DATA_CNT
        |=> !sdo_q ##1 !sdo_q)
        else $error("status trailer not zero");

    a_status_layout: assert property (
        @(posedge spi_sclk_i) disable iff (!rst_n_i)
        state_q == spi_byte_port_pkg::ST_TGT && spi_cs_i && op_q[1]
        && spi_sdi_i
        |=> (shift_q & ~spi_byte_port_pkg::STATUS_USED_MASK) == 8'h00
            && shift_q[spi_byte_port_pkg::RX_FULL_BIT] == $past(!rx_free))
        else $error("status byte layout wrong");

    a_rx_hold: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        rx_valid_q && !rx_ready_i |=> rx_valid_q && $stable(rx_out_q))
        else $error("rx byte dropped");

    a_tx_handoff: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        tx_valid_i && tx_ready_q
        |=> !tx_ready_q && tx_hold_q == $past(tx_data_i))
        else $error("tx slot overrun");

    c_data_read: cover property (
        @(posedge spi_sclk_i) disable iff (!rst_n_i)
        state_q == spi_byte_port_pkg::ST_STAT
        && op_q == spi_byte_port_pkg::OP_READ && rd_ok_q);

    c_write_reject: cover property (
        @(posedge spi_sclk_i) disable iff (!rst_n_i)
        state_q == spi_byte_port_pkg::ST_STAT && spi_cs_i
        && op_q == spi_byte_port_pkg::OP_WRITE && !rx_free);

    c_status_chain: cover property (
        @(posedge spi_sclk_i) disable iff (!rst_n_i)
        state_q == spi_byte_port_pkg::ST_FINAL
        && op_q == spi_byte_port_pkg::OP_STATUS ##1 spi_cs_i && spi_sdi_i);

    c_abort: cover property (
        @(posedge spi_sclk_i) disable iff (!rst_n_i)
        state_q == spi_byte_port_pkg::ST_DATA && !spi_cs_i);

endmodule

// >>> logic/spi_byte_port_pkg.sv
// Constants, types and encodings for the byte-wide SPI slave port.
// Assumes one system clock domain and one SPI clock domain driven by
// the external master; nothing here holds state.
package spi_byte_port_pkg;

    // --------------------------------------------------------------
    // Link figures
    // --------------------------------------------------------------
    localparam int unsigned SCLK_MAX_MHZ  = 12;
    localparam int unsigned FRAME_CYCLES  = 13;
    localparam int unsigned DATA_BITS     = 8;
    localparam logic [2:0]  LAST_DATA_CNT = 3'h7;
    localparam logic [2:0]  CNT_RESET     = 3'h0;
    localparam logic [7:0]  BYTE_RESET    = 8'h00;

    // --------------------------------------------------------------
    // Status byte layout
    // --------------------------------------------------------------
    localparam int unsigned RX_FULL_BIT      = 0;
    localparam int unsigned TX_EMPTY_BIT     = 1;
    localparam int unsigned RX_IRQ_EN_BIT    = 4;
    localparam int unsigned TX_IRQ_EN_BIT    = 5;
    localparam logic [7:0]  STATUS_USED_MASK = 8'h33;

    // --------------------------------------------------------------
    // Per-transaction status bit values
    // --------------------------------------------------------------
    localparam logic STAT_OK  = 1'b0;
    localparam logic STAT_BAD = 1'b1;

    // Operation code is {direction, target}
    typedef enum logic [1:0] {
        OP_WRITE  = 2'b00,
        OP_NONE   = 2'b01,
        OP_READ   = 2'b10,
        OP_STATUS = 2'b11
    } op_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_DIR   = 3'b001,
        ST_TGT   = 3'b010,
        ST_DATA  = 3'b011,
        ST_STAT  = 3'b100,
        ST_FINAL = 3'b101
    } link_state_t;

endpackage

// >>> testbench/spi_master_model.sv
// Behavioural SPI master that frames one-byte transfers for the port.
// Assumes one caller at a time; the clock stands still between frames.
`timescale 1ns/1ps
module spi_master_model (
    output logic      sclk_o,
    output logic      cs_o,
    output logic      sdi_o,
    input  wire logic sdo_i
);
    localparam time HALF = 15;

    initial begin
        sclk_o = 1'b0;
        cs_o   = 1'b0;
        sdi_o  = 1'b0;
    end

    // master clocks, rising sample
    // Lines move on the falling edge so each rising edge sees them settled
    task automatic tick(input logic cs, input logic d, output logic s);
        cs_o   = cs;
        sdi_o  = d;
        #HALF;
        s      = sdo_i;
        sclk_o = 1'b1;
        #HALF;
        sclk_o = 1'b0;
    endtask

    // thirteen edges, select held for the first cs_edges
    // Idle edges around the frame also let the synchronisers settle;
    // an idle data line toggles so a stale level is never mistaken
    task automatic frame(input logic [1:0] op, input logic [7:0] wb,
                         input int cs_edges, output logic [7:0] rb,
                         output logic st);
        logic [12:0] s;
        logic        x;
        int          k;
        for (k = 0; k < 3; k++) tick(1'b0, ~sdi_o, x);
        for (k = 0; k < 13; k++) begin
            tick(k < cs_edges, (k == 0) ? 1'b1 : (k < 3) ? op[2 - k] :
                 (k < 11) ? wb[10 - k] : ~sdi_o, s[k]);
        end
        for (k = 0; k < 2; k++) tick(1'b0, ~sdi_o, x);
        for (k = 0; k < 8; k++) rb[7 - k] = s[3 + k];
        st = (op == 2'b00) ? s[12] : s[11];
    endtask
endmodule

// >>> testbench/spi_slave_byte_port_tb_top.sv
// Self-checking bench for the byte-wide SPI slave port.
// Assumes the master model drives the link; system side driven here.
`timescale 1ns/1ps
module spi_slave_byte_port_tb_top;
    logic        ref_clk_i;
    logic        rst_n_i;
    logic        sclk;
    logic        cs;
    logic        sdi;
    logic        sdo;
    logic [7:0]  tx_data_i;
    logic        tx_valid_i;
    logic        tx_ready_o;
    logic [7:0]  rx_data_o;
    logic        rx_valid_o;
    logic        rx_ready_i;
    logic        rx_ie;
    logic        tx_ie;
    logic [7:0]  rb;
    logic [7:0]  b;
    logic        st;
    logic [31:0] r;
    int          fail_count;
    int          compares;
    int          seed;
    int          i;

    spi_slave_byte_port u_dut (
        .ref_clk_i            (ref_clk_i),
        .rst_n_i              (rst_n_i),
        .spi_sclk_i           (sclk),
        .spi_cs_i             (cs),
        .spi_sdi_i            (sdi),
        .spi_sdo_o            (sdo),
        .tx_data_i            (tx_data_i),
        .tx_valid_i           (tx_valid_i),
        .tx_ready_o           (tx_ready_o),
        .rx_data_o            (rx_data_o),
        .rx_valid_o           (rx_valid_o),
        .rx_ready_i           (rx_ready_i),
        .rx_full_irq_enable_i (rx_ie),
        .tx_empty_irq_enable_i(tx_ie)
    );

    spi_master_model u_master (
        .sclk_o(sclk),
        .cs_o  (cs),
        .sdi_o (sdi),
        .sdo_i (sdo)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp,
                            input string m);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string m);
        chk_byte({7'h00, got}, {7'h00, exp}, m);
    endtask

    function automatic logic [7:0] exp_status(input logic rxf,
                                              input logic txe);
        exp_status = 8'h00;
        exp_status[spi_byte_port_pkg::RX_FULL_BIT]   = rxf;
        exp_status[spi_byte_port_pkg::TX_EMPTY_BIT]  = txe;
        exp_status[spi_byte_port_pkg::RX_IRQ_EN_BIT] = rx_ie;
        exp_status[spi_byte_port_pkg::TX_IRQ_EN_BIT] = tx_ie;
    endfunction

    task automatic status(input logic rxf, input logic txe);
        u_master.frame(2'b11, 8'h00, 13, rb, st);
        chk_byte(rb, exp_status(rxf, txe), "status byte");
        chk_bit(st, 1'b0, "status bit");
    endtask

    // Waits for a free slot, then hands one byte over
    task automatic load_tx(input logic [7:0] v);
        int n;
        for (n = 0; n < 200 && tx_ready_o !== 1'b1; n++) @(negedge ref_clk_i);
        chk_bit(tx_ready_o, 1'b1, "tx slot free");
        @(posedge ref_clk_i);
        tx_data_i  <= v;
        tx_valid_i <= 1'b1;
        @(posedge ref_clk_i);
        tx_valid_i <= 1'b0;
    endtask

    task automatic test_done;
        $display("Counts: fail_count %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Far more than the whole sequence needs
    initial begin
        #100000;
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        test_done();
    end

    initial begin
        seed       = 32'h0335469C;
        fail_count = 0;
        compares   = 0;
        rst_n_i    = 1'b0;
        tx_data_i  = 8'h00;
        tx_valid_i = 1'b0;
        rx_ready_i = 1'b0;
        rx_ie      = 1'b0;
        tx_ie      = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        for (i = 0; i < 4; i++) begin
            r = $random(seed);
            @(posedge ref_clk_i);
            rx_ie <= r[0];
            tx_ie <= r[1];
            @(posedge ref_clk_i);
            status(1'b0, 1'b1);
        end
        u_master.frame(2'b10, 8'h00, 13, rb, st);
        chk_bit(st, spi_byte_port_pkg::STAT_BAD, "empty read");
        u_master.frame(2'b01, 8'h00, 13, rb, st);
        chk_bit(st, spi_byte_port_pkg::STAT_BAD, "unused op");
        for (i = 0; i < 6; i++) begin
            r = $random(seed);
            b = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : r[7:0];
            load_tx(b);
            u_master.frame(2'b10, 8'h00, 13, rb, st);
            chk_byte(rb, b, "read byte");
            chk_bit(st, spi_byte_port_pkg::STAT_OK, "read status");
        end
        for (i = 0; i < 4; i++) begin
            r = $random(seed);
            b = r[7:0];
            u_master.frame(2'b00, b, 13, rb, st);
            chk_bit(st, spi_byte_port_pkg::STAT_OK, "write ok");
            @(negedge ref_clk_i);
            chk_bit(rx_valid_o, 1'b1, "rx valid");
            chk_byte(rx_data_o, b, "rx byte");
            u_master.frame(2'b00, ~b, 13, rb, st);
            chk_bit(st, spi_byte_port_pkg::STAT_BAD, "write full");
            status(1'b1, 1'b1);
            @(negedge ref_clk_i);
            chk_byte(rx_data_o, b, "rx kept");
            @(posedge ref_clk_i);
            rx_ready_i <= 1'b1;
            @(posedge ref_clk_i);
            rx_ready_i <= 1'b0;
            // Rejected byte goes again once the slot is drained
            u_master.frame(2'b00, ~b, 13, rb, st);
            chk_bit(st, spi_byte_port_pkg::STAT_OK, "resend ok");
            @(negedge ref_clk_i);
            chk_bit(rx_valid_o, 1'b1, "resend valid");
            chk_byte(rx_data_o, ~b, "resent byte");
            @(posedge ref_clk_i);
            rx_ready_i <= 1'b1;
            @(posedge ref_clk_i);
            rx_ready_i <= 1'b0;
        end
        // Select dropped mid-frame must leave both slots untouched
        u_master.frame(2'b00, 8'hA5, 7, rb, st);
        repeat (10) @(negedge ref_clk_i);
        chk_bit(rx_valid_o, 1'b0, "abort write");
        load_tx(8'h3C);
        u_master.frame(2'b10, 8'h00, 6, rb, st);
        u_master.frame(2'b10, 8'h00, 13, rb, st);
        chk_byte(rb, 8'h3C, "read after abort");
        chk_bit(st, spi_byte_port_pkg::STAT_OK, "abort kept");
        status(1'b0, 1'b1);
        test_done();
    end
endmodule
